// [dcam_top.sv]
// dual-channel interleaved ddr2 address decode, suspend and pin control
`include "dcam_regs.svh"

module dcam_top
   import dcam_pkg::*;
#(
   parameter int ADDR_W   = `DCAM_ADDR_W,
   parameter int OUTST_W  = `DCAM_OUTST_W,
   parameter int EXIT_CYC = `DCAM_SREF_EXIT_CYC
) (
   input  wire logic                    i_clk,
   input  wire logic                    i_rst_n,
   input  dcam_tech_t                   i_tech,
   input  wire logic [3:0]              i_rank_present,
   input  wire logic                    i_req_valid,
   input  wire logic [ADDR_W-1:0]       i_req_addr,
   input  wire logic                    i_req_write,
   output logic                         o_req_ready,
   output logic                         o_req_err,
   output logic                         o_cmd_valid,
   input  wire logic                    i_cmd_ready,
   output logic                         o_cmd_chan,
   output logic [1:0]                   o_cmd_rank,
   output logic [`DCAM_BANK_W-1:0]      o_cmd_bank,
   output logic [`DCAM_ROW_W-1:0]       o_cmd_row,
   output logic [`DCAM_COL_W-1:0]       o_cmd_col,
   output logic                         o_cmd_write,
   input  wire logic                    i_cycle_done,
   input  wire logic                    i_suspend_req,
   output logic                         o_sref_enter,
   output logic                         o_suspended,
   output logic [11:0]                  o_ck_p,
   output logic [11:0]                  o_ck_n,
   output logic [7:0]                   o_cke,
   output logic [7:0]                   o_odt
);
   dcam_state_t                 st_r,      st_nxt;
   logic                        vld_r,     vld_nxt;
   logic                        chan_r,    chan_nxt;
   logic [1:0]                  rank_r,    rank_nxt;
   logic [`DCAM_BANK_W-1:0]     bank_r,    bank_nxt;
   logic [`DCAM_ROW_W-1:0]      row_r,     row_nxt;
   logic [`DCAM_COL_W-1:0]      col_r,     col_nxt;
   logic                        wr_r,      wr_nxt;
   logic                        err_r,     err_nxt;
   logic                        sref_r,    sref_nxt;
   logic                        cke_on_r,  cke_on_nxt;
   logic [OUTST_W-1:0]          outst_r,   outst_nxt;
   logic [7:0]                  wait_r,    wait_nxt;

   logic [`DCAM_BANK_W-1:0]     d_bank;
   logic [`DCAM_ROW_W-1:0]      d_row;
   logic [`DCAM_COL_W-1:0]      d_col;
   logic [4:0]                  d_top;
   logic [ADDR_W-1:0]           d_hi;
   logic                        d_oor;
   logic                        fire;
   logic                        take;
   logic                        room;

   // address decode
   always_comb begin
      d_bank = '0;
      d_row  = '0;
      d_col  = '0;
      d_top  = `DCAM_TOP_256X8;
      d_col[2:0] = i_req_addr[5:3];
      d_col[8:3] = i_req_addr[12:7];
      d_row[10:0] = i_req_addr[27:17];
      case (i_tech)
         DCAM_TECH_256X8: begin
            d_col[9]  = i_req_addr[13];
            d_bank    = {1'b0, i_req_addr[15:14]};
            d_row[11] = i_req_addr[16];
            d_row[12] = i_req_addr[28];
            d_top     = `DCAM_TOP_256X8;
         end
         DCAM_TECH_256X16: begin
            // bit 13 is bank 1 here
            d_bank    = {1'b0, i_req_addr[13], i_req_addr[14]};
            d_row[11] = i_req_addr[16];
            d_row[12] = i_req_addr[15];
            d_top     = `DCAM_TOP_256X16;
         end
         DCAM_TECH_512X8: begin
            d_col[9]  = i_req_addr[13];
            d_bank    = {1'b0, i_req_addr[15:14]};
            d_row[11] = i_req_addr[16];
            d_row[12] = i_req_addr[28];
            d_row[13] = i_req_addr[29];
            d_top     = `DCAM_TOP_512X8;
         end
         DCAM_TECH_512X16: begin
            d_col[9]  = i_req_addr[13];
            d_bank    = {1'b0, i_req_addr[15:14]};
            d_row[11] = i_req_addr[16];
            d_row[12] = i_req_addr[28];
            d_top     = `DCAM_TOP_512X16;
         end
         DCAM_TECH_1GX8: begin
            d_col[9]  = i_req_addr[13];
            d_bank    = {i_req_addr[14], i_req_addr[15], i_req_addr[16]};
            // 1Gb row 11 and row 13
            d_row[11] = i_req_addr[29];
            d_row[12] = i_req_addr[28];
            d_row[13] = i_req_addr[30];
            d_top     = `DCAM_TOP_1GX8;
         end
         DCAM_TECH_1GX16: begin
            d_col[9]  = i_req_addr[13];
            d_bank    = {i_req_addr[14], i_req_addr[15], i_req_addr[16]};
            d_row[11] = i_req_addr[29];
            d_row[12] = i_req_addr[28];
            d_top     = `DCAM_TOP_1GX16;
         end
         default: begin
            d_top = `DCAM_TOP_256X8;
         end
      endcase
      // rank pairs stack above the interleaved span
      d_hi  = i_req_addr >> (d_top + 5'h1);
      d_oor = (|d_hi[ADDR_W-1:2]) || !i_rank_present[d_hi[1:0]];
   end

   assign fire = vld_r && i_cmd_ready;
   assign room = !vld_r || i_cmd_ready;
   assign o_req_ready = (st_r == DCAM_ST_RUN) && room;
   assign take = i_req_valid && o_req_ready;

   always_comb begin
      st_nxt     = st_r;
      vld_nxt    = vld_r && !i_cmd_ready;
      chan_nxt   = chan_r;
      rank_nxt   = rank_r;
      bank_nxt   = bank_r;
      row_nxt    = row_r;
      col_nxt    = col_r;
      wr_nxt     = wr_r;
      err_nxt    = 1'b0;
      sref_nxt   = 1'b0;
      cke_on_nxt = cke_on_r;
      wait_nxt   = wait_r;
      outst_nxt  = outst_r;
      if (fire && !i_cycle_done) begin
         outst_nxt = outst_r + OUTST_W'(1);
      end else if (!fire && i_cycle_done && outst_r != '0) begin
         outst_nxt = outst_r - OUTST_W'(1);
      end
      // out-of-range requests are answered with an error, never issued
      if (take) begin
         if (d_oor) begin
            err_nxt = 1'b1;
         end else begin
            vld_nxt  = 1'b1;
            chan_nxt = i_req_addr[`DCAM_CHAN_BIT];
            rank_nxt = d_hi[1:0];
            bank_nxt = d_bank;
            row_nxt  = d_row;
            col_nxt  = d_col;
            wr_nxt   = i_req_write;
         end
      end
      case (st_r)
         DCAM_ST_RUN: begin
            if (i_suspend_req) begin
               st_nxt = DCAM_ST_DRAIN;
            end
         end
         DCAM_ST_DRAIN: begin
            if (!vld_r && outst_r == '0) begin
               st_nxt   = DCAM_ST_SREF;
               sref_nxt = 1'b1;
               // cke low by the time suspend shows
               // the pin stage adds a flop, so cke must drop here
               cke_on_nxt = 1'b0;
            end
         end
         DCAM_ST_SREF: begin
            cke_on_nxt = 1'b0;
            st_nxt     = DCAM_ST_SUSP;
         end
         DCAM_ST_SUSP: begin
            if (!i_suspend_req) begin
               cke_on_nxt = 1'b1;
               wait_nxt   = 8'(EXIT_CYC);
               st_nxt     = DCAM_ST_EXIT;
            end
         end
         DCAM_ST_EXIT: begin
            // hold off requests until exit time passes
            if (wait_r <= 8'h1) begin
               wait_nxt = 8'h0;
               st_nxt   = DCAM_ST_RUN;
            end else begin
               wait_nxt = wait_r - 8'h1;
            end
         end
         default: begin
            st_nxt = DCAM_ST_RUN;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         st_r     <= DCAM_ST_RUN;
         vld_r    <= 1'b0;
         chan_r   <= 1'b0;
         rank_r   <= 2'h0;
         bank_r   <= '0;
         row_r    <= '0;
         col_r    <= '0;
         wr_r     <= 1'b0;
         err_r    <= 1'b0;
         sref_r   <= 1'b0;
         cke_on_r <= 1'b1;
         outst_r  <= '0;
         wait_r   <= 8'h0;
      end else begin
         st_r     <= st_nxt;
         vld_r    <= vld_nxt;
         chan_r   <= chan_nxt;
         rank_r   <= rank_nxt;
         bank_r   <= bank_nxt;
         row_r    <= row_nxt;
         col_r    <= col_nxt;
         wr_r     <= wr_nxt;
         err_r    <= err_nxt;
         sref_r   <= sref_nxt;
         cke_on_r <= cke_on_nxt;
         outst_r  <= outst_nxt;
         wait_r   <= wait_nxt;
      end
   end

   assign o_cmd_valid  = vld_r;
   assign o_cmd_chan   = chan_r;
   assign o_cmd_rank   = rank_r;
   assign o_cmd_bank   = bank_r;
   assign o_cmd_row    = row_r;
   assign o_cmd_col    = col_r;
   assign o_cmd_write  = wr_r;
   assign o_req_err    = err_r;
   assign o_sref_enter = sref_r;
   assign o_suspended  = (st_r == DCAM_ST_SUSP);

   // both channels see the same population in interleaved mode
   for (genvar c = 0; c < 2; c++) begin : g_chan
      dcam_chan_pins u_pins (
         .i_clk          (i_clk),
         .i_rst_n        (i_rst_n),
         .i_dimm_present ({|i_rank_present[3:2], |i_rank_present[1:0]}),
         .i_rank_present (i_rank_present),
         .i_cke_on       (cke_on_r),
         .i_cmd_fire     (fire && (chan_r == 1'(c))),
         .i_cmd_rank     (rank_r),
         .i_cmd_write    (wr_r),
         .o_ck_p         (o_ck_p[c*6 +: 6]),
         .o_ck_n         (o_ck_n[c*6 +: 6]),
         .o_cke          (o_cke[c*4 +: 4]),
         .o_odt          (o_odt[c*4 +: 4])
      );
   end
endmodule

// [dcam_regs.svh]
// named constants for the dual-channel ddr2 address map block
`ifndef DCAM_REGS_SVH
`define DCAM_REGS_SVH

// host address bit that picks the channel
`define DCAM_CHAN_BIT      6
// host address width and field widths
`define DCAM_ADDR_W        33
`define DCAM_ROW_W         14
`define DCAM_BANK_W        3
`define DCAM_COL_W         10
// highest host bit used inside one rank pair, per technology
`define DCAM_TOP_256X8     5'h1c
`define DCAM_TOP_256X16    5'h1b
`define DCAM_TOP_512X8     5'h1d
`define DCAM_TOP_512X16    5'h1c
`define DCAM_TOP_1GX8      5'h1e
`define DCAM_TOP_1GX16     5'h1d
// clock pairs per dimm and dimms per channel
`define DCAM_CK_PER_DIMM   3
`define DCAM_DIMMS         2
`define DCAM_RANKS         4
// timing
`define DCAM_CLK_NS        20
`define DCAM_SREF_EXIT_NS  200
`define DCAM_SREF_EXIT_CYC \
   ((`DCAM_SREF_EXIT_NS + `DCAM_CLK_NS - 1) / `DCAM_CLK_NS)
`define DCAM_ODT_HOLD_CYC  4
`define DCAM_OUTST_W       4

`endif

// [dcam_pkg.sv]
// types shared by the address map block
package dcam_pkg;

   typedef enum logic [2:0] {
      DCAM_TECH_256X8,
      DCAM_TECH_256X16,
      DCAM_TECH_512X8,
      DCAM_TECH_512X16,
      DCAM_TECH_1GX8,
      DCAM_TECH_1GX16
   } dcam_tech_t;

   typedef enum logic [2:0] {
      DCAM_ST_RUN,
      DCAM_ST_DRAIN,
      DCAM_ST_SREF,
      DCAM_ST_SUSP,
      DCAM_ST_EXIT
   } dcam_state_t;

endpackage

// [dcam_chan_pins.sv]
// per-channel dimm clock, cke and odt pin drive
`include "dcam_regs.svh"
module dcam_chan_pins #(
   parameter int CK_PER_DIMM = `DCAM_CK_PER_DIMM,
   parameter int DIMMS       = `DCAM_DIMMS,
   parameter int ODT_HOLD    = `DCAM_ODT_HOLD_CYC
) (
   input  wire logic                           i_clk,
   input  wire logic                           i_rst_n,
   input  wire logic [DIMMS-1:0]               i_dimm_present,
   input  wire logic [2*DIMMS-1:0]             i_rank_present,
   input  wire logic                           i_cke_on,
   input  wire logic                           i_cmd_fire,
   input  wire logic [1:0]                     i_cmd_rank,
   input  wire logic                           i_cmd_write,
   output logic      [CK_PER_DIMM*DIMMS-1:0]   o_ck_p,
   output logic      [CK_PER_DIMM*DIMMS-1:0]   o_ck_n,
   output logic      [2*DIMMS-1:0]             o_cke,
   output logic      [2*DIMMS-1:0]             o_odt
);
   logic                 ck_r,     ck_nxt;
   logic [2*DIMMS-1:0]   cke_r,    cke_nxt;
   logic [2*DIMMS-1:0]   odt_r,    odt_nxt;
   logic [3:0]           hold_r,   hold_nxt;
   logic [2*DIMMS-1:0]   odt_pick;
   logic                 tgt_dimm;

   always_comb begin
      ck_nxt   = ~ck_r;
      cke_nxt  = i_cke_on ? i_rank_present : '0;
      tgt_dimm = i_cmd_rank[1];
      odt_pick = '0;
      // odt from config and target
      // the idle dimm terminates; a lone dimm terminates itself on writes
      // the concatenation keeps the inversion one bit wide
      if (i_dimm_present[~tgt_dimm]) begin
         odt_pick[{~tgt_dimm, 1'b0}] = i_rank_present[{~tgt_dimm, 1'b0}];
      end else if (i_cmd_write) begin
         odt_pick[i_cmd_rank] = i_rank_present[i_cmd_rank];
      end
      odt_nxt  = odt_r;
      hold_nxt = hold_r;
      if (i_cmd_fire) begin
         odt_nxt  = odt_pick;
         hold_nxt = 4'(ODT_HOLD);
      end else if (hold_r != 4'h0) begin
         hold_nxt = hold_r - 4'h1;
      end else begin
         odt_nxt  = '0;
      end
      if (!i_cke_on) begin
         odt_nxt = '0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ck_r   <= 1'b0;
         cke_r  <= '0;
         odt_r  <= '0;
         hold_r <= 4'h0;
      end else begin
         ck_r   <= ck_nxt;
         cke_r  <= cke_nxt;
         odt_r  <= odt_nxt;
         hold_r <= hold_nxt;
      end
   end

   for (genvar d = 0; d < DIMMS; d++) begin : g_dimm
      assign o_ck_p[d*CK_PER_DIMM +: CK_PER_DIMM] =
         {CK_PER_DIMM{ck_r & i_dimm_present[d]}};
      assign o_ck_n[d*CK_PER_DIMM +: CK_PER_DIMM] =
         {CK_PER_DIMM{~ck_r & i_dimm_present[d]}};
   end
   assign o_cke = cke_r;
   assign o_odt = odt_r;
endmodule

// [dcam_top_assertions.sv]
// concurrent checks on the address map block's ports
module dcam_top_chk #(
   parameter int ADDR_W = 33
) (
   input wire logic              i_clk,
   input wire logic              i_rst_n,
   input wire logic [3:0]        i_rank_present,
   input wire logic              i_req_valid,
   input wire logic [ADDR_W-1:0] i_req_addr,
   input wire logic              o_req_ready,
   input wire logic              o_req_err,
   input wire logic              o_cmd_valid,
   input wire logic              i_cmd_ready,
   input wire logic              o_cmd_chan,
   input wire logic [1:0]        o_cmd_rank,
   input wire logic [13:0]       o_cmd_row,
   input wire logic [9:0]        o_cmd_col,
   input wire logic              i_cycle_done,
   input wire logic              i_suspend_req,
   input wire logic              o_sref_enter,
   input wire logic              o_suspended,
   input wire logic [11:0]       o_ck_p,
   input wire logic [11:0]       o_ck_n,
   input wire logic [7:0]        o_cke,
   input wire logic [7:0]        o_odt
);
   timeunit 1ns;
   timeprecision 100ps;
   logic        take;
   logic        fire;
   logic [5:0]  dimm_on;
   logic [11:0] ck_mask;
   logic [5:0]  outst_r;
   logic [5:0]  outst_nxt;

   assign take    = i_req_valid && o_req_ready;
   assign fire    = o_cmd_valid && i_cmd_ready;
   assign dimm_on = {{3{|i_rank_present[3:2]}}, {3{|i_rank_present[1:0]}}};
   assign ck_mask = {dimm_on, dimm_on};

   // cycles issued but not yet completed, seen from the ports only
   always_comb begin
      outst_nxt = outst_r + 6'(fire) - 6'(i_cycle_done);
   end
   always_ff @(posedge i_clk) begin
      if (!i_rst_n)
         outst_r <= 6'h00;
      else
         outst_r <= outst_nxt;
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   a_chan_bit: assert property (take |=> o_req_err ||
      o_cmd_valid && o_cmd_chan == $past(i_req_addr[6]))
      else $error("channel select not from host bit 6");
   a_col_bits: assert property (take |=> o_req_err ||
      o_cmd_col[8:0] == {$past(i_req_addr[12:7]), $past(i_req_addr[5:3])})
      else $error("low column bits misplaced");
   a_row_bits: assert property (take |=> o_req_err ||
      o_cmd_row[10:0] == $past(i_req_addr[27:17]))
      else $error("low row bits misplaced");
   a_ck_pairs: assert property ((o_ck_p ^ o_ck_n) == ck_mask)
      else $error("clock pair not differential for a present dimm");
   a_sref_drain: assert property (o_sref_enter |->
      outst_r == 6'h00 && !o_cmd_valid)
      else $error("self refresh entered with cycles pending");
   a_cke_sref: assert property (o_sref_enter |=> o_cke == 8'h00)
      else $error("cke not low after self refresh entry");
   a_cke_susp: assert property (o_suspended |-> o_cke == 8'h00)
      else $error("cke high while suspended");
   a_odt_peer: assert property (fire && !o_cmd_rank[1] &&
      i_rank_present[2] |=> o_odt[{$past(o_cmd_chan), 2'b10}])
      else $error("peer dimm termination not enabled");
   a_susp_idle: assert property (o_suspended |->
      !o_req_ready && !o_cmd_valid)
      else $error("request path open while suspended");
   a_exit_wait: assert property ($fell(o_suspended) |->
      !o_req_ready [*8])
      else $error("request accepted before self refresh exit");
   a_cke_wake: assert property (o_suspended && !i_suspend_req |=>
      ##1 o_cke == {i_rank_present, i_rank_present})
      else $error("cke not restored on resume");
endmodule

bind dcam_top dcam_top_chk #(.ADDR_W(ADDR_W)) u_dcam_top_chk (
   .i_clk, .i_rst_n, .i_rank_present, .i_req_valid, .i_req_addr,
   .o_req_ready, .o_req_err, .o_cmd_valid, .i_cmd_ready, .o_cmd_chan,
   .o_cmd_rank, .o_cmd_row, .o_cmd_col, .i_cycle_done, .i_suspend_req,
   .o_sref_enter, .o_suspended, .o_ck_p, .o_ck_n, .o_cke, .o_odt
);

// [dcam_dimm_model.sv]
// dimm-side model: command acceptance and cycle completion
module dcam_dimm_model (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_slow,
   input  wire logic i_cmd_valid,
   output logic      o_cmd_ready,
   output logic      o_cycle_done
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] cnt_r;
   logic [1:0] cnt_nxt;
   logic [6:0] pend_r;
   logic [6:0] pend_nxt;

   always_comb begin
      cnt_nxt  = cnt_r + 2'h1;
      pend_nxt = {pend_r[5:0], i_cmd_valid && o_cmd_ready};
   end
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         cnt_r  <= 2'h0;
         pend_r <= 7'h00;
      end else begin
         cnt_r  <= cnt_nxt;
         pend_r <= pend_nxt;
      end
   end
   // slow mode takes one slot in four, so drains wait
   assign o_cmd_ready  = !i_slow || cnt_r == 2'h3;
   // one fixed latency: switching modes never reports a cycle twice
   assign o_cycle_done = pend_r[6];
endmodule

// [dual_channel_ddr2_addr_map_tb.sv]
// self-checking bench for the dual-channel address map block
module dual_channel_ddr2_addr_map_tb
   import dcam_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int TOPS [6] = '{28, 27, 29, 28, 30, 29};
   localparam logic [32:0] PAT [3] =
      '{33'h1_a5c3_96f8, 33'h0_5a3c_6907, 33'h1_ffff_ffbf};
   logic        i_clk = 1'b0;
   logic        i_rst_n, i_req_valid, i_req_write, i_cmd_ready, slow;
   logic        i_cycle_done, i_suspend_req, o_req_ready, o_req_err;
   logic        o_cmd_valid, o_cmd_chan, o_cmd_write, o_sref_enter;
   logic        o_suspended;
   dcam_tech_t  i_tech;
   logic [3:0]  i_rank_present;
   logic [32:0] i_req_addr;
   logic [1:0]  o_cmd_rank;
   logic [2:0]  o_cmd_bank;
   logic [13:0] o_cmd_row;
   logic [9:0]  o_cmd_col;
   logic [11:0] o_ck_p, o_ck_n;
   logic [7:0]  o_cke, o_odt;
   int          errors = 0;
   int          n_tests = 0;

   dcam_top #(.EXIT_CYC(10)) u_dcam_top (
      .i_clk, .i_rst_n, .i_tech, .i_rank_present, .i_req_valid,
      .i_req_addr, .i_req_write, .o_req_ready, .o_req_err, .o_cmd_valid,
      .i_cmd_ready, .o_cmd_chan, .o_cmd_rank, .o_cmd_bank, .o_cmd_row,
      .o_cmd_col, .o_cmd_write, .i_cycle_done, .i_suspend_req,
      .o_sref_enter, .o_suspended, .o_ck_p, .o_ck_n, .o_cke, .o_odt);
   dcam_dimm_model u_dcam_dimm_model (
      .i_clk, .i_rst_n, .i_slow(slow), .i_cmd_valid(o_cmd_valid),
      .o_cmd_ready(i_cmd_ready), .o_cycle_done(i_cycle_done));

   always #10 i_clk = ~i_clk;

   task automatic tick();
      @(posedge i_clk);
      #1;
   endtask

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      n_tests++;
      if (exp !== got) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic summarize();
      $display("comparisons %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // holds the request until taken; returns just after the taking edge
   task automatic send(input logic [32:0] a, input logic wr);
      int n = 0;
      // an edge between calls keeps valid from falling and rising at once
      tick();
      i_req_valid = 1'b1;
      i_req_addr  = a;
      i_req_write = wr;
      while (o_req_ready !== 1'b1 && n < 50) begin
         tick();
         n++;
      end
      tick();
      i_req_valid = 1'b0;
   endtask

   // {chan, bank, row, col} expected for a technology
   function automatic logic [27:0] exp_dec(dcam_tech_t t, logic [32:0] a);
      logic [13:0] r;
      logic [2:0]  b;
      logic [9:0]  c;
      c = {a[13], a[12:7], a[5:3]};
      r = {1'b0, a[28], a[16], a[27:17]};
      b = {1'b0, a[15], a[14]};
      case (t)
         DCAM_TECH_256X16: begin
            c[9]  = 1'b0;
            r[12] = a[15];
            b     = {1'b0, a[13], a[14]};
         end
         DCAM_TECH_512X8: r[13] = a[29];
         DCAM_TECH_1GX8, DCAM_TECH_1GX16: begin
            r[11] = a[29];
            r[13] = (t == DCAM_TECH_1GX8) ? a[30] : 1'b0;
            b     = {a[14], a[15], a[16]};
         end
         default: ;
      endcase
      return {a[6], b, r, c};
   endfunction

   task automatic t_decode();
      logic [32:0] a;
      int          top;
      for (int t = 0; t < 6; t++) begin
         i_tech = dcam_tech_t'(t);
         top    = TOPS[t];
         for (int k = 0; k < 4; k++) begin
            a = (PAT[k % 3] & ((33'h1 << (top + 1)) - 33'h1))
                | (33'(k) << (top + 1));
            send(a, k[0]);
            if (k == 3)
               chk("absent rank", 32'h1, 32'(o_req_err));
            else begin
               chk("fields", 32'(exp_dec(i_tech, a)), 32'({o_cmd_chan,
                   o_cmd_bank, o_cmd_row, o_cmd_col}));
               chk("rank", 32'(k), 32'(o_cmd_rank));
               chk("write", 32'(k[0]), 32'(o_cmd_write));
            end
         end
      end
   endtask

   task automatic t_clocks();
      logic [11:0] prev;
      repeat (3) begin
         prev = o_ck_p;
         tick();
         chk("ck toggle", 32'(prev ^ 12'hfff), 32'(o_ck_p));
         chk("ck pair", 32'hfff, 32'(o_ck_p ^ o_ck_n));
      end
   endtask

   task automatic t_suspend();
      int n = 0;
      slow = 1'b1;
      send(33'h0_0000_0040, 1'b1);
      i_suspend_req = 1'b1;
      tick();
      chk("ready in drain", 32'h0, 32'(o_req_ready));
      while (o_sref_enter !== 1'b1 && n < 100) begin
         tick();
         n++;
      end
      chk("sref", 32'h1, 32'(o_sref_enter));
      chk("drained", 32'h0, 32'(o_cmd_valid));
      tick();
      chk("cke off", 32'h0, 32'(o_cke));
      repeat (20) tick();
      chk("cke held", 32'h0, 32'(o_cke));
      chk("suspended", 32'h1, 32'(o_suspended));
      i_suspend_req = 1'b0;
      // cke passes the state flop and then the pin flop
      tick();
      tick();
      chk("cke wake", 32'h77, 32'(o_cke));
      n = 0;
      while (o_req_ready !== 1'b1 && n < 50) begin
         tick();
         n++;
      end
      chk("exit wait", 32'h1, 32'(n >= 8 && n < 50));
      slow = 1'b0;
      send(33'h0_0000_0008, 1'b0);
      chk("resumed cmd", 32'h1, 32'(o_cmd_valid));
      tick();
      chk("odt peer", 32'h4, 32'(o_odt));
   endtask

   initial begin
      i_rst_n        = 1'b0;
      i_req_valid    = 1'b0;
      i_req_write    = 1'b0;
      i_req_addr     = 33'h0_0000_0000;
      i_suspend_req  = 1'b0;
      i_tech         = DCAM_TECH_256X8;
      i_rank_present = 4'h7;
      slow           = 1'b0;
      repeat (5) @(posedge i_clk);
      #1;
      i_rst_n = 1'b1;
      chk("idle", 32'h0, 32'({o_cmd_valid, o_odt}));
      tick();
      chk("cke on", 32'h77, 32'(o_cke));
      t_decode();
      t_clocks();
      t_suspend();
      repeat (8) tick();
      chk("odt off", 32'h0, 32'(o_odt));
      summarize();
   end

   // the whole run needs well under a thousand cycles
   initial begin
      #(20 * 5000);
      errors++;
      summarize();
   end
endmodule
